// ### inc/van_diag_pkg.sv
// Behaviour
// - one conductor failing moves nominal to degraded, receiving on the healthy wire (only in automatic mode; forced modes keep their input)
// - failing conductor healthy again returns to nominal, differential input reconnected (in automatic mode; forced wire modes keep their wire)
// - both conductors failing enters major error
// - two line-state bits: 00 nominal, 01/10 degraded, 11 major error
// - in major error, reception alternates between wires every diagnosis clock period
// - mismatch flag sets when one input disagrees with the other two
// - mismatch flag is cleared only by return-to-idle or general reset
// - each input filtered: change accepted after five equal samples at 1/16 timeslot
// - four edges on one wire, none on the other: the silent wire is faulty
// - fewer than four edges on the selected input per diagnosis period: major error
// - while transmitting dominant, a wire seen recessive is faulty (only while the other wire reads dominant; both recessive flags neither)
// - eight consecutive dominant timeslots is a protocol fault leading to major error
// - degraded to major error on a silent diagnosis period or protocol fault
// - automatic mode: two fault-free diagnosis clock edges return to nominal
// - one-cycle return-to-idle pulse at each detected end of frame, except in automatic mode
// - return-to-idle restores nominal only in forced modes, suppressed in automatic
// - diagnosis clock from divider or software trigger, used only in automatic mode
// - transmit checking only while the tx-in-progress enable is set
// - tx-in-progress starts at frame start, identifier, or reply bit
// - tx-in-progress ends after end of frame, lost arbitration, or code violation
// - tx-in-progress never asserts for an acknowledge-only transmission
// - mode 00 differential, 01 wire b, 10 wire a, 11 automatic
// - divider divides timeslots by 64 shifted left by the four-bit code
// - pulsed coding: differential input only, diagnosis inactive
package van_diag_pkg;

  localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] STAT_OFS = 32'h0000_0004;
  localparam logic [31:0] CMD_OFS = 32'h0000_0008;
  localparam int DIV_CODE_POS = 4;
  localparam int MODE_POS = 2;
  localparam int TXEN_POS = 1;
  localparam int DIVEN_POS = 0;
  localparam int PULSED_POS = 8;
  localparam int MSDC_POS = 0;
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam int SAMPLES_PER_SLOT = 16;
  localparam int FILTER_LEN = 5;
  localparam int EDGE_LIMIT = 4;
  localparam int DOM_LIMIT = 8;
  localparam int DIV_BASE_LOG2 = 6;
  localparam int DIV_W = 22;
  localparam logic [1:0] MODE_DIFF = 2'h0;
  localparam logic [1:0] MODE_WIRE_B = 2'h1;
  localparam logic [1:0] MODE_WIRE_A = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h3;

  typedef enum logic [1:0] {
    ST_NOMINAL = 2'b00,
    ST_DEG_B = 2'b01,
    ST_DEG_A = 2'b10,
    ST_MAJOR = 2'b11
  } line_state_t;

  typedef struct packed {
    logic pulsed;
    logic [3:0] diag_divider_code;
    logic [1:0] select_mode;
    logic tx_diag_enable;
    logic diag_divider_enable;
  } diag_ctrl_t;

  typedef struct packed {
    logic sof_start;
    logic id_start;
    logic rtr_start;
    logic eof_done;
    logic arb_lost;
    logic code_viol;
    logic ack_only;
  } frame_evt_t;

endpackage : van_diag_pkg

// ### rtl/van_glitch_filter.sv
`timescale 1ns/10ps
module van_glitch_filter
  import van_diag_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // sampling
  input wire logic sample,
  input wire logic din,
  // filtered level and edge pulse
  output logic dout,
  output logic edge_pulse
);

  logic [2:0] run_r;

  // a change counts only after FILTER_LEN matching samples
  always_ff @(posedge clk) begin
    if (!rstn) begin
      run_r <= 3'h0;
      dout <= 1'b1;
      edge_pulse <= 1'b0;
    end else begin
      edge_pulse <= 1'b0;
      if (sample) begin
        if (din == dout) begin
          run_r <= 3'h0;
        end else if (run_r == 3'(FILTER_LEN - 1)) begin
          run_r <= 3'h0;
          dout <= din;
          edge_pulse <= 1'b1;
        end else begin
          run_r <= run_r + 3'h1;
        end
      end
    end
  end

endmodule : van_glitch_filter

// ### rtl/van_tip_gen.sv
`timescale 1ns/10ps
module van_tip_gen
  import van_diag_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control and frame events
  input wire logic enable,
  input wire frame_evt_t evt,
  // result
  output logic tx_in_progress
);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_in_progress <= 1'b0;
    end else if (!enable) begin
      tx_in_progress <= 1'b0;
    end else if (evt.eof_done || evt.arb_lost || evt.code_viol) begin
      tx_in_progress <= 1'b0;
    end else if ((evt.sof_start || evt.id_start || evt.rtr_start) && !evt.ack_only) begin
      tx_in_progress <= 1'b1;
    end
  end

endmodule : van_tip_gen

// ### rtl/van_line_diagnosis.sv
`timescale 1ns/10ps
module van_line_diagnosis
  import van_diag_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // line receivers, low is dominant
  input wire logic diff_rx_in,
  input wire logic wire_a_rx_in,
  input wire logic wire_b_rx_in,
  // timing strobes from the bit-rate generator
  input wire logic slot_tick,
  input wire logic sample_tick,
  // transmit side
  input wire logic tx_out,
  input wire frame_evt_t frame_evt,
  // reception path and diagnosis outputs
  output logic rx_selected,
  output logic return_to_idle_pulse,
  output logic sync_diag_clock,
  output logic tx_in_progress,
  output logic line_state_hi,
  output logic line_state_lo,
  output logic input_mismatch_flag
);

  diag_ctrl_t ctrl_r;
  line_state_t state_r;
  line_state_t state_nxt;
  logic mismatch_r;
  logic manual_trig_r;
  logic [DIV_W-1:0] div_cnt_r;
  logic sdc_r;
  logic sdc_seen_r;
  logic [2:0] edges_a_r;
  logic [2:0] edges_b_r;
  logic [2:0] edges_sel_r;
  logic [3:0] dom_cnt_r;
  logic slot_dom_r;
  logic [1:0] ok_sdc_r;
  logic alt_r;
  logic [1:0] tx_hist_r;
  logic f_diff;
  logic f_a;
  logic f_b;
  logic e_diff;
  logic e_a;
  logic e_b;
  logic sdc_pulse;
  logic diag_on;
  logic auto_mode;
  logic fail_a;
  logic fail_b;
  logic proto_fault;
  logic sel_quiet;
  logic apb_wr;
  logic apb_rd;

  function automatic logic [2:0] sat_inc(input logic [2:0] v, input logic hit);
    sat_inc = (hit && v != 3'(EDGE_LIMIT)) ? v + 3'h1 : v;
  endfunction : sat_inc

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // control register and one-shot manual trigger
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_r <= diag_ctrl_t'(CTRL_RST);
      manual_trig_r <= 1'b0;
    end else begin
      manual_trig_r <= 1'b0;
      if (apb_wr && paddr[7:0] == CTRL_OFS[7:0]) begin
        ctrl_r <= diag_ctrl_t'(pwdata[8:0]);
      end
      if (apb_wr && paddr[7:0] == CMD_OFS[7:0]) begin
        manual_trig_r <= pwdata[MSDC_POS];
      end
    end
  end

  // read data registered in setup phase; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd && !penable) begin
      case (paddr[7:0])
        CTRL_OFS[7:0]: prdata <= {23'h000000, ctrl_r};
        STAT_OFS[7:0]: prdata <= {29'h0000000, mismatch_r, state_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign auto_mode = ctrl_r.select_mode == MODE_AUTO;
  assign diag_on = !ctrl_r.pulsed;

  van_glitch_filter u_filt_diff (
    .clk(clk),
    .rstn(rstn),
    .sample(sample_tick),
    .din(diff_rx_in),
    .dout(f_diff),
    .edge_pulse(e_diff)
  );

  van_glitch_filter u_filt_a (
    .clk(clk),
    .rstn(rstn),
    .sample(sample_tick),
    .din(wire_a_rx_in),
    .dout(f_a),
    .edge_pulse(e_a)
  );

  van_glitch_filter u_filt_b (
    .clk(clk),
    .rstn(rstn),
    .sample(sample_tick),
    .din(wire_b_rx_in),
    .dout(f_b),
    .edge_pulse(e_b)
  );

  van_tip_gen u_tip (
    .clk(clk),
    .rstn(rstn),
    .enable(ctrl_r.tx_diag_enable),
    .evt(frame_evt),
    .tx_in_progress(tx_in_progress)
  );

  // diagnosis clock: divider of timeslots or software trigger
  always_ff @(posedge clk) begin
    if (!rstn) begin
      div_cnt_r <= '0;
      sdc_r <= 1'b0;
    end else if (!ctrl_r.diag_divider_enable) begin
      div_cnt_r <= '0;
      sdc_r <= 1'b0;
    end else if (slot_tick) begin
      if (div_cnt_r == DIV_W'((64'd1 << (DIV_BASE_LOG2 + ctrl_r.diag_divider_code)) - 64'd1)) begin
        div_cnt_r <= '0;
        sdc_r <= 1'b1;
      end else begin
        div_cnt_r <= div_cnt_r + DIV_W'(1);
        sdc_r <= 1'b0;
      end
    end else begin
      sdc_r <= 1'b0;
    end
  end

  // the clock only matters in automatic mode
  assign sdc_pulse = auto_mode && diag_on && (sdc_r || manual_trig_r);
  assign sync_diag_clock = sdc_r || manual_trig_r;

  // end of frame marks the per-frame inspection point
  always_ff @(posedge clk) begin
    if (!rstn) begin
      return_to_idle_pulse <= 1'b0;
    end else begin
      // automatic selection keeps no per-frame recovery point
      return_to_idle_pulse <= frame_evt.eof_done && !auto_mode;
    end
  end

  // edge counters reset at each diagnosis period in automatic mode and at end of frame in forced modes
  always_ff @(posedge clk) begin
    if (!rstn || sdc_pulse || return_to_idle_pulse) begin
      edges_a_r <= 3'h0;
      edges_b_r <= 3'h0;
      edges_sel_r <= 3'h0;
    end else begin
      edges_a_r <= sat_inc(edges_a_r, e_a);
      edges_b_r <= sat_inc(edges_b_r, e_b);
      edges_sel_r <= sat_inc(edges_sel_r, rx_sel_edge(state_r));
    end
  end

  function automatic logic rx_sel_edge(input line_state_t s);
    case (s)
      ST_DEG_B: rx_sel_edge = e_a;
      ST_DEG_A: rx_sel_edge = e_b;
      ST_MAJOR: rx_sel_edge = alt_r ? e_b : e_a;
      default: rx_sel_edge = e_diff;
    endcase
  endfunction : rx_sel_edge

  assign sel_quiet = edges_sel_r < 3'(EDGE_LIMIT);

  // consecutive dominant timeslots
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dom_cnt_r <= 4'h0;
      slot_dom_r <= 1'b1;
    end else if (slot_tick) begin
      slot_dom_r <= 1'b1;
      if (slot_dom_r && !f_diff) begin
        dom_cnt_r <= (dom_cnt_r == 4'(DOM_LIMIT)) ? dom_cnt_r : dom_cnt_r + 4'h1;
      end else begin
        dom_cnt_r <= 4'h0;
      end
    end else if (f_diff && f_a && f_b) begin
      slot_dom_r <= 1'b0;
    end
  end

  assign proto_fault = dom_cnt_r == 4'(DOM_LIMIT);

  // tx history needs two dominant tx_out samples before comparing
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_hist_r <= 2'b11;
    end else if (sample_tick) begin
      tx_hist_r <= {tx_hist_r[0], tx_out};
    end
  end

  // a wire is faulty when silent against four edges, or recessive against a dominant other wire while we drive dominant
  always_comb begin
    fail_a = (edges_b_r == 3'(EDGE_LIMIT)) && (edges_a_r == 3'h0);
    fail_b = (edges_a_r == 3'(EDGE_LIMIT)) && (edges_b_r == 3'h0);
    if (tx_in_progress && tx_hist_r == 2'b00 && f_a != f_b) begin
      fail_a = fail_a || f_a;
      fail_b = fail_b || f_b;
    end
  end

  // fault-free diagnosis clock edges counted for automatic recovery
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ok_sdc_r <= 2'h0;
      alt_r <= 1'b0;
      sdc_seen_r <= 1'b0;
    end else if (sdc_pulse) begin
      alt_r <= !alt_r;
      sdc_seen_r <= 1'b1;
      if (fail_a || fail_b || proto_fault || sel_quiet) begin
        ok_sdc_r <= 2'h0;
      end else if (ok_sdc_r != 2'h2) begin
        ok_sdc_r <= ok_sdc_r + 2'h1;
      end
    end else if (state_r == ST_NOMINAL) begin
      ok_sdc_r <= 2'h0;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_NOMINAL: begin
        if (fail_a && fail_b) begin
          state_nxt = ST_MAJOR;
        end else if (fail_a) begin
          state_nxt = ST_DEG_A;
        end else if (fail_b) begin
          state_nxt = ST_DEG_B;
        end else if (proto_fault || (sdc_pulse && sdc_seen_r && sel_quiet)) begin
          state_nxt = ST_MAJOR;
        end
      end
      ST_DEG_A, ST_DEG_B: begin
        if ((state_r == ST_DEG_A && fail_b) || (state_r == ST_DEG_B && fail_a)) begin
          state_nxt = ST_MAJOR;
        end else if (proto_fault || (sdc_pulse && sdc_seen_r && sel_quiet)) begin
          state_nxt = ST_MAJOR;
        end else if (sdc_pulse && ok_sdc_r == 2'h1) begin
          state_nxt = ST_NOMINAL;
        end
      end
      ST_MAJOR: begin
        if (sdc_pulse && ok_sdc_r == 2'h1) begin
          state_nxt = ST_NOMINAL;
        end
      end
      default: state_nxt = ST_NOMINAL;
    endcase
    // forced modes recover at end of frame; automatic ignores it
    if (return_to_idle_pulse && !auto_mode) begin
      state_nxt = ST_NOMINAL;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || !diag_on) begin
      state_r <= ST_NOMINAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  // a set in the same cycle as the clearing pulse wins
  // pulsed coding stops the comparison but the flag waits for idle or reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mismatch_r <= 1'b0;
    end else if (diag_on && !(f_diff == f_a && f_a == f_b)) begin
      mismatch_r <= 1'b1;
    end else if (return_to_idle_pulse) begin
      mismatch_r <= 1'b0;
    end
  end

  // reception path: forced modes pick the input, automatic follows the state
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_selected <= 1'b1;
    end else if (!diag_on) begin
      rx_selected <= f_diff;
    end else begin
      case (ctrl_r.select_mode)
        MODE_DIFF: rx_selected <= f_diff;
        MODE_WIRE_B: rx_selected <= f_b;
        MODE_WIRE_A: rx_selected <= f_a;
        default: begin
          case (state_r)
            ST_DEG_B: rx_selected <= f_a;
            ST_DEG_A: rx_selected <= f_b;
            ST_MAJOR: rx_selected <= alt_r ? f_b : f_a;
            default: rx_selected <= f_diff;
          endcase
        end
      endcase
    end
  end

  assign line_state_hi = state_r[1];
  assign line_state_lo = state_r[0];
  assign input_mismatch_flag = mismatch_r;

endmodule : van_line_diagnosis

// ### test/van_bus_model.sv
`timescale 1ns/10ps
module van_bus_model
  import van_diag_pkg::*;
(
  // clock
  input wire logic clk,
  // bus level and conductor faults
  input wire logic bus_level,
  input wire logic open_a,
  input wire logic open_b,
  // receivers and strobes
  output logic diff_rx_in,
  output logic wire_a_rx_in,
  output logic wire_b_rx_in,
  output logic slot_tick,
  output logic sample_tick
);
  // free running: the bit-rate generator does not follow the device reset
  logic [4:0] tick_cnt_r = 5'h00;
  always_ff @(posedge clk) begin
    tick_cnt_r <= tick_cnt_r + 5'h01;
  end
  assign sample_tick = tick_cnt_r[0];
  assign slot_tick = (tick_cnt_r == 5'h1F);
  // an open conductor floats recessive at its single-wire receiver
  assign diff_rx_in = bus_level;
  assign wire_a_rx_in = bus_level | open_a;
  assign wire_b_rx_in = bus_level | open_b;
endmodule : van_bus_model

// ### test/van_diag_chk.sv
`timescale 1ns/10ps
module van_diag_chk
  import van_diag_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // watched ports
  input wire frame_evt_t frame_evt,
  input wire logic return_to_idle_pulse,
  input wire logic sync_diag_clock,
  input wire logic tx_in_progress,
  input wire logic line_state_hi,
  input wire logic line_state_lo,
  input wire logic input_mismatch_flag
);
  logic [1:0] st;
  logic stop;
  assign st = {line_state_hi, line_state_lo};
  assign stop = frame_evt.eof_done | frame_evt.arb_lost | frame_evt.code_viol;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  rti_cause_a: assert property (return_to_idle_pulse |->
    $past(frame_evt.eof_done)) else $error("idle pulse without end of frame");
  rti_width_a: assert property (return_to_idle_pulse |=>
    !return_to_idle_pulse) else $error("idle pulse too long");
  tip_start_a: assert property ($rose(tx_in_progress) |->
    $past(frame_evt.sof_start | frame_evt.id_start | frame_evt.rtr_start))
    else $error("tip rose without start");
  tip_stop_a: assert property (stop |=> !tx_in_progress)
    else $error("tip kept after stop");
  tip_ack_a: assert property (frame_evt.ack_only && !tx_in_progress |=>
    !tx_in_progress) else $error("tip on acknowledge only");
  flag_hold_a: assert property (input_mismatch_flag && !return_to_idle_pulse &&
    !frame_evt.eof_done |=> input_mismatch_flag) else $error("mismatch flag lost");
  nom_return_a: assert property ($changed(st) && st == ST_NOMINAL |->
    $past(return_to_idle_pulse) || $past(frame_evt.eof_done) || $past(sync_diag_clock)
    || $past(sync_diag_clock, 2)) else $error("nominal without cause");
  sdc_width_a: assert property (sync_diag_clock |=> !sync_diag_clock)
    else $error("diagnosis clock too long");
  cover property (return_to_idle_pulse);
  cover property (st == ST_MAJOR);
  cover property ($rose(input_mismatch_flag));
endmodule : van_diag_chk

bind van_line_diagnosis van_diag_chk i_van_diag_chk (.clk, .rstn, .frame_evt,
  .return_to_idle_pulse, .sync_diag_clock, .tx_in_progress, .line_state_hi,
  .line_state_lo, .input_mismatch_flag);

// ### test/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import van_diag_pkg::*;
;
  localparam int SL = 32; // clocks per timeslot, as the bus model makes them
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0;
  logic bus_level = 1'b1, open_a = 1'b0, open_b = 1'b0, tx_out = 1'b1;
  frame_evt_t frame_evt = '0;
  logic [31:0] prdata, rdata;
  logic rerr;
  logic pready, pslverr, diff_rx_in, wire_a_rx_in, wire_b_rx_in, slot_tick, sample_tick;
  logic rx_selected, return_to_idle_pulse, sync_diag_clock, tx_in_progress, ev_rti;
  logic line_state_hi, line_state_lo, input_mismatch_flag;
  int errors = 0, comparisons = 0, cyc = 0;

  van_bus_model i_van_bus_model (.clk, .bus_level, .open_a, .open_b, .diff_rx_in,
    .wire_a_rx_in, .wire_b_rx_in, .slot_tick, .sample_tick);
  van_line_diagnosis i_van_line_diagnosis (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .diff_rx_in, .wire_a_rx_in, .wire_b_rx_in,
    .slot_tick, .sample_tick, .tx_out, .frame_evt, .rx_selected, .return_to_idle_pulse,
    .sync_diag_clock, .tx_in_progress, .line_state_hi, .line_state_lo, .input_mismatch_flag);

  initial forever #2.5 clk = ~clk;

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      $display("FAIL %0t timeout", $time);
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_st(input logic [1:0] exp);
    chk(32'({line_state_hi, line_state_lo}), 32'(exp));
  endtask : chk_st

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr_mode(input logic [1:0] m, input logic tx);
    apb(1'b1, CTRL_OFS, (32'(m) << MODE_POS) | (32'(tx) << TXEN_POS));
  endtask : wr_mode

  task automatic trig();
    apb(1'b1, CMD_OFS, 32'h1 << MSDC_POS);
    step(4);
  endtask : trig

  // each level is held past a timeslot so the five-sample filter accepts it
  task automatic toggle(input int n);
    repeat (n) begin
      @(posedge clk);
      bus_level <= !bus_level;
      step(SL + 8);
    end
  endtask : toggle

  task automatic evt(input logic [6:0] e);
    @(posedge clk);
    frame_evt <= frame_evt_t'(e);
    @(posedge clk);
    frame_evt <= '0;
    @(posedge clk);
    ev_rti = return_to_idle_pulse;
    step(3);
  endtask : evt

  task automatic do_reset();
    @(posedge clk);
    rstn <= 1'b0;
    step(3);
    rstn <= 1'b1;
    step(1);
  endtask : do_reset

  task automatic t_regs();
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rdata, 32'(CTRL_RST));
    apb(1'b0, STAT_OFS, 32'h0);
    chk(rdata, 32'h0);
    apb(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
    apb(1'b0, 32'h0000_0040, 32'h0);
    chk(rdata, 32'h0);
    chk(32'(rerr), 32'h0);
    apb(1'b1, CTRL_OFS, 32'h0000_00F6);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rdata, 32'h0000_00F6);
    wr_mode(MODE_DIFF, 1'b0);
  endtask : t_regs

  task automatic t_fault(input logic a);
    open_a <= a;
    open_b <= !a;
    toggle(6);
    chk_st(a ? ST_DEG_A : ST_DEG_B);
    chk(32'(input_mismatch_flag), 32'h1);
    apb(1'b0, STAT_OFS, 32'h0);
    chk(rdata, {29'h0, 1'b1, a, !a});
    open_a <= 1'b0;
    open_b <= 1'b0;
    step(SL);
    evt(7'h08);
    chk(32'(ev_rti), 32'h1);
    chk_st(ST_NOMINAL);
    chk(32'(input_mismatch_flag), 32'h0);
  endtask : t_fault

  task automatic t_auto();
    logic r1;
    wr_mode(MODE_AUTO, 1'b0);
    open_b <= 1'b1;
    toggle(6);
    chk_st(ST_DEG_B);
    bus_level <= 1'b0;
    step(SL + 8);
    chk(32'(rx_selected), 32'h0);
    bus_level <= 1'b1;
    step(SL + 8);
    evt(7'h08);
    chk(32'(ev_rti), 32'h0);
    chk_st(ST_DEG_B);
    open_b <= 1'b0;
    trig();
    toggle(6);
    trig();
    toggle(6);
    trig();
    chk_st(ST_NOMINAL);
    trig();
    chk_st(ST_MAJOR);
    open_a <= 1'b1;
    bus_level <= 1'b0;
    step(SL + 8);
    trig();
    r1 = rx_selected;
    trig();
    chk(32'(rx_selected), 32'(!r1));
    bus_level <= 1'b1;
    open_a <= 1'b0;
    do_reset();
    chk_st(ST_NOMINAL);
    chk(32'(input_mismatch_flag), 32'h0);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rdata, 32'(CTRL_RST));
  endtask : t_auto

  task automatic t_proto();
    bus_level <= 1'b0;
    step(6 * SL);
    chk_st(ST_NOMINAL);
    chk(32'(input_mismatch_flag), 32'h0);
    step(4 * SL);
    chk_st(ST_MAJOR);
    bus_level <= 1'b1;
    step(2 * SL);
    evt(7'h08);
    chk_st(ST_NOMINAL);
  endtask : t_proto

  task automatic t_tx();
    int i;
    wr_mode(MODE_DIFF, 1'b1);
    for (i = 0; i < 3; i++) begin
      evt(7'h40 >> i);
      chk(32'(tx_in_progress), 32'h1);
      evt(7'h08 >> i);
      chk(32'(tx_in_progress), 32'h0);
    end
    evt(7'h41);
    chk(32'(tx_in_progress), 32'h0);
    evt(7'h40);
    open_a <= 1'b1;
    tx_out <= 1'b0;
    bus_level <= 1'b0;
    step(3 * SL);
    chk_st(ST_DEG_A);
    tx_out <= 1'b1;
    bus_level <= 1'b1;
    open_a <= 1'b0;
    step(SL);
    evt(7'h08);
    wr_mode(MODE_DIFF, 1'b0);
    evt(7'h40);
    chk(32'(tx_in_progress), 32'h0);
  endtask : t_tx

  task automatic t_modes();
    open_a <= 1'b1;
    bus_level <= 1'b0;
    wr_mode(MODE_WIRE_A, 1'b0);
    step(SL);
    chk(32'(rx_selected), 32'h1);
    wr_mode(MODE_WIRE_B, 1'b0);
    step(2);
    chk(32'(rx_selected), 32'h0);
    apb(1'b1, CTRL_OFS, (32'h1 << PULSED_POS) | (32'(MODE_WIRE_A) << MODE_POS));
    step(2);
    chk(32'(rx_selected), 32'h0);
    chk(32'(input_mismatch_flag), 32'h1);
    wr_mode(MODE_DIFF, 1'b0);
    bus_level <= 1'b1;
    open_a <= 1'b0;
    step(SL);
    evt(7'h08);
    chk(32'(input_mismatch_flag), 32'h0);
  endtask : t_modes

  task automatic t_div();
    int n = 0;
    apb(1'b1, CTRL_OFS, 32'h1 << DIVEN_POS);
    @(negedge clk);
    while (sync_diag_clock !== 1'b1) @(negedge clk);
    @(negedge clk);
    while (sync_diag_clock !== 1'b1) begin
      n++;
      @(negedge clk);
    end
    chk(32'(n + 1), 32'(64 * SL));
  endtask : t_div

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_fault(1'b0);
    t_fault(1'b1);
    t_auto();
    t_proto();
    t_tx();
    t_modes();
    t_div();
    report_and_stop();
  end
endmodule : tb_top
